// [rtl/ccp_defines.vh]
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH
// Register offsets (7-bit command address)
`define CCP_ADDR_CTRL      7'h00
`define CCP_ADDR_PACK_CONFIG_BYTE     7'h7C
`define CCP_ADDR_ID3       7'h7D
`define CCP_ADDR_DISCHARGE_RATE_COMP_CONSTANTS     7'h7E
`define CCP_ADDR_TEMPERATURE_COMP_CONSTANTS     7'h7F
// Pack configuration fields
`define CCP_PK_QV_HI       6
`define CCP_PK_QV_LO       5
`define CCP_PK_DCFIX       1
`define CCP_PK_TCFIX       0
// Fixed compensation bytes and ship command byte
`define CCP_DISCHARGE_RATE_COMP_CONSTANTS_FIXED    8'h42
`define CCP_TEMPERATURE_COMP_CONSTANTS_FIXED    8'h7C
`define CCP_SHIP_CMD       8'hA9
// Termination voltages, mV; Kelvin value of zero Celsius
`define CCP_TV_00          13'h0F80
`define CCP_TV_01          13'h0FB0
`define CCP_TV_10          13'h0FE0
`define CCP_TV_11          13'h1010
`define CCP_KELVIN_ZERO    10'h111
// Reset values
`define CCP_RST_BYTE       8'h00
// Timing
`define CCP_CLK_HZ         50000000
`define CCP_LOW_SEC        16
`define CCP_WAKE_SEC       14400
`define CCP_CHECK_SEC      900
`define CCP_NOACT_SEC      1800
`define CCP_CHECK_EVERY    2'h3
`define CCP_MIN_PULSES     2
// Power modes
`define CCP_MODE_ACTIVE    3'h0
`define CCP_MODE_SLEEP     3'h1
`define CCP_MODE_WAKE      3'h2
`define CCP_MODE_SHIP      3'h3
`define CCP_MODE_HIBER     3'h4
`endif

// [rtl/ccp_sec_tick.v]
`timescale 1ns/1ns
`include "ccp_defines.vh"
module ccp_sec_tick #(
  parameter CYC_PER_SEC = `CCP_CLK_HZ
) (
  // Clock and reset
  input  wire ref_clk_in,
  input  wire arst_n_in,
  // Tick
  output reg  sec_tick_out
);
  reg [31:0] cnt_q;
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q        <= 32'h0;
      sec_tick_out <= 1'b0;
    end else if (cnt_q == CYC_PER_SEC - 1) begin
      cnt_q        <= 32'h0;
      sec_tick_out <= 1'b1;
    end else begin
      cnt_q        <= cnt_q + 32'h1;
      sec_tick_out <= 1'b0;
    end
  end
endmodule // ccp_sec_tick

// [rtl/ccp_comp_math.v]
`timescale 1ns/1ns
`include "ccp_defines.vh"
module ccp_comp_math (
  // Configuration
  input  wire [7:0]  discharge_rate_comp_constants_in,
  input  wire [7:0]  temperature_comp_constants_in,
  // Gauge values
  input  wire [15:0] nominal_available_charge_in,
  input  wire [15:0] learned_full_capacity_in,
  input  wire [15:0] initial_full_capacity_in,
  input  wire [15:0] average_current_in,
  input  wire [9:0]  temp_kelvin_in,
  input  wire [15:0] discharge_comp_adjust_in,
  input  wire [15:0] temp_comp_adjust_in,
  // Results
  output wire [15:0] discharge_comp_value_out,
  output wire [15:0] temp_comp_value_out,
  output wire [15:0] rate_compensated_charge_out,
  output wire [15:0] temp_compensated_charge_out,
  output wire        cold_out
);
  wire [5:0]  discharge_comp_gain      = discharge_rate_comp_constants_in[7:2];
  wire [1:0]  discharge_comp_threshold = discharge_rate_comp_constants_in[1:0];
  wire [3:0]  temp_comp_gain           = temperature_comp_constants_in[7:4];
  wire [3:0]  temp_comp_offset         = temperature_comp_constants_in[3:0];
  reg  [15:0] thr;
  wire [9:0]  tlim = `CCP_KELVIN_ZERO + {6'h0, temp_comp_offset};
  always @* begin
    if (discharge_comp_threshold == 2'h0) thr = 16'h0;
    else if (discharge_comp_threshold == 2'h1)
      thr = {1'b0, learned_full_capacity_in[15:1]};
    else if (discharge_comp_threshold == 2'h2)
      thr = {2'h0, learned_full_capacity_in[15:2]};
    else thr = {3'h0, learned_full_capacity_in[15:3]};
  end
  // Gain step is 1/256 of excess current (0.39%)
  wire [15:0] excess = (average_current_in > thr) ?
                       average_current_in - thr : 16'h0;
  wire [21:0] dprod  = {6'h0, excess} * {16'h0, discharge_comp_gain};
  assign discharge_comp_value_out = {2'h0, dprod[21:8]};
  assign rate_compensated_charge_out =
    (discharge_comp_value_out > discharge_comp_adjust_in) ?
    nominal_available_charge_in -
    (discharge_comp_value_out - discharge_comp_adjust_in) :
    nominal_available_charge_in;
  assign cold_out = temp_kelvin_in < tlim;
  // Gain slope scale is 25 percent of capacity per step per degree (1/4 of capacity per step)
  wire [9:0]  tdel  = cold_out ? tlim - temp_kelvin_in : 10'h0;
  wire [29:0] tprod = {14'h0, initial_full_capacity_in} *
                      {20'h0, tdel} * {26'h0, temp_comp_gain};
  wire [27:0] tq    = tprod[29:2];
  assign temp_comp_value_out = (|tq[27:16]) ? 16'hFFFF : tq[15:0];
  assign temp_compensated_charge_out = rate_compensated_charge_out -
    (temp_comp_value_out - temp_comp_adjust_in);
endmodule // ccp_comp_math

// [rtl/ccp_capacity_comp.v]
`timescale 1ns/1ns
`include "ccp_defines.vh"
module ccp_capacity_comp #(
  parameter LOW_CYC   = `CCP_LOW_SEC,
  parameter WAKE_SEC  = `CCP_WAKE_SEC,
  parameter CHECK_SEC = `CCP_CHECK_SEC,
  parameter NOACT_SEC = `CCP_NOACT_SEC,
  parameter CYC_PER_SEC = `CCP_CLK_HZ
) (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        arst_n_in,
  // Register write/read port from the line engine
  input  wire        reg_wr_in,
  input  wire [6:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  input  wire        ship_bit_in,
  // Gauge values
  input  wire [15:0] nominal_available_charge_in,
  input  wire [15:0] learned_full_capacity_in,
  input  wire [15:0] initial_full_capacity_in,
  input  wire [15:0] average_current_in,
  input  wire [9:0]  temp_kelvin_in,
  input  wire        first_end_voltage_event_in,
  input  wire        full_charge_event_in,
  // Activity and power
  input  wire        host_one_wire_line_in,
  input  wire [3:0]  magnitude_filter_in,
  input  wire        activity_in,
  input  wire        current_converter_pulse_in,
  input  wire        supply_above_por_in,
  input  wire        backup_supply_pin_in,
  // Results
  output reg  [12:0] term_voltage_mv_out,
  output reg  [15:0] rate_compensated_charge_out,
  output reg  [15:0] temp_compensated_charge_out,
  output reg  [9:0]  sleep_temp_kelvin_out,
  output reg         learn_disqualify_out,
  output reg  [2:0]  power_mode_out,
  output wire        gauge_enable_out,
  output wire        self_discharge_en_out,
  output wire        retain_state_out
);
  reg  [7:0]  pack_config_byte_q;
  reg  [7:0]  id3_q;
  reg  [7:0]  discharge_rate_comp_constants_q;
  reg  [7:0]  temperature_comp_constants_q;
  reg  [15:0] discharge_comp_adjust_q;
  reg  [15:0] temp_comp_adjust_q;
  reg         ship_armed_q;
  reg  [2:0]  mode_q;
  reg  [13:0] sec_cnt_q;
  reg  [10:0] act_cnt_q;
  reg  [1:0]  wake_idx_q;
  reg  [1:0]  pulse_cnt_q;
  reg  [10:0] win_cnt_q;
  reg         wake_check_q;
  reg         check_busy_q;
  reg  [4:0]  low_cnt_q;
  wire        sec_tick;
  wire [15:0] dcv;
  wire [15:0] tcv;
  wire [15:0] rate_compensated_charge;
  wire [15:0] temp_compensated_charge;
  wire        cold;

  // Fixed bytes replace the programmed ones
  wire [7:0] discharge_rate_comp_constants_use = pack_config_byte_q[`CCP_PK_DCFIX] ? `CCP_DISCHARGE_RATE_COMP_CONSTANTS_FIXED
                                                : discharge_rate_comp_constants_q;
  wire [7:0] temperature_comp_constants_use = pack_config_byte_q[`CCP_PK_TCFIX] ? `CCP_TEMPERATURE_COMP_CONSTANTS_FIXED
                                                : temperature_comp_constants_q;

  ccp_sec_tick #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_tick (
    .ref_clk_in   (ref_clk_in),
    .arst_n_in    (arst_n_in),
    .sec_tick_out (sec_tick)
  );

  ccp_comp_math u_math (
    .discharge_rate_comp_constants_in                    (discharge_rate_comp_constants_use),
    .temperature_comp_constants_in                    (temperature_comp_constants_use),
    .nominal_available_charge_in (nominal_available_charge_in),
    .learned_full_capacity_in    (learned_full_capacity_in),
    .initial_full_capacity_in    (initial_full_capacity_in),
    .average_current_in          (average_current_in),
    .temp_kelvin_in              (temp_kelvin_in),
    .discharge_comp_adjust_in    (discharge_comp_adjust_q),
    .temp_comp_adjust_in         (temp_comp_adjust_q),
    .discharge_comp_value_out    (dcv),
    .temp_comp_value_out         (tcv),
    .rate_compensated_charge_out (rate_compensated_charge),
    .temp_compensated_charge_out (temp_compensated_charge),
    .cold_out                    (cold)
  );

  function [12:0] term_mv;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    term_mv = `CCP_TV_00;
        2'h1:    term_mv = `CCP_TV_01;
        2'h2:    term_mv = `CCP_TV_10;
        default: term_mv = `CCP_TV_11;
      endcase
    end
  endfunction

  always @* begin
    if (reg_addr_in == `CCP_ADDR_PACK_CONFIG_BYTE) reg_rdata_out = pack_config_byte_q;
    else if (reg_addr_in == `CCP_ADDR_ID3) reg_rdata_out = id3_q;
    else if (reg_addr_in == `CCP_ADDR_DISCHARGE_RATE_COMP_CONSTANTS) reg_rdata_out = discharge_rate_comp_constants_q;
    else if (reg_addr_in == `CCP_ADDR_TEMPERATURE_COMP_CONSTANTS) reg_rdata_out = temperature_comp_constants_q;
    else reg_rdata_out = 8'h00;
  end

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pack_config_byte_q <= `CCP_RST_BYTE;
      id3_q   <= `CCP_RST_BYTE;
      discharge_rate_comp_constants_q <= `CCP_RST_BYTE;
      temperature_comp_constants_q <= `CCP_RST_BYTE;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `CCP_ADDR_PACK_CONFIG_BYTE) pack_config_byte_q <= reg_wdata_in;
      else if (reg_addr_in == `CCP_ADDR_ID3) id3_q <= reg_wdata_in;
      else if (reg_addr_in == `CCP_ADDR_DISCHARGE_RATE_COMP_CONSTANTS) discharge_rate_comp_constants_q <= reg_wdata_in;
      else if (reg_addr_in == `CCP_ADDR_TEMPERATURE_COMP_CONSTANTS) temperature_comp_constants_q <= reg_wdata_in;
    end
  end

  // Outputs and adjustments; gauging frozen outside active modes
  wire gauging = (mode_q == `CCP_MODE_ACTIVE) ||
                 (mode_q == `CCP_MODE_WAKE);
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      discharge_comp_adjust_q     <= 16'h0;
      temp_comp_adjust_q          <= 16'h0;
      term_voltage_mv_out         <= 13'h0;
      rate_compensated_charge_out <= 16'h0;
      temp_compensated_charge_out <= 16'h0;
      learn_disqualify_out        <= 1'b0;
    end else if (gauging) begin
      term_voltage_mv_out <= term_mv({pack_config_byte_q[`CCP_PK_QV_HI],
                                      pack_config_byte_q[`CCP_PK_QV_LO]});
      rate_compensated_charge_out <= rate_compensated_charge;
      temp_compensated_charge_out <= temp_compensated_charge;
      learn_disqualify_out        <= cold;
      if (first_end_voltage_event_in) begin
        discharge_comp_adjust_q <= dcv;
        temp_comp_adjust_q      <= tcv;
      end else if (full_charge_event_in) begin
        temp_comp_adjust_q      <= 16'h0;
      end
    end
  end

  // Activity: filter zero means count converter pulses per window
  wire quiet = (magnitude_filter_in == 4'h0) ?
               (pulse_cnt_q < `CCP_MIN_PULSES) : !activity_in;
  wire ship_cmd = reg_wr_in && (reg_addr_in == `CCP_ADDR_CTRL) &&
                  (reg_wdata_in == `CCP_SHIP_CMD) && ship_bit_in;
  wire line_low_done = (low_cnt_q >= LOW_CYC);

  // Zero filter: converter pulses per fixed window of CHECK_SEC seconds
  // Pulse on the window edge is dropped; one count of error accepted
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      win_cnt_q   <= 11'h0;
      pulse_cnt_q <= 2'h0;
    end else if (sec_tick && win_cnt_q == CHECK_SEC - 1) begin
      win_cnt_q   <= 11'h0;
      pulse_cnt_q <= 2'h0;
    end else begin
      if (sec_tick) win_cnt_q <= win_cnt_q + 11'h1;
      if (current_converter_pulse_in && pulse_cnt_q != 2'h3)
        pulse_cnt_q <= pulse_cnt_q + 2'h1;
    end
  end

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q           <= `CCP_MODE_ACTIVE;
      ship_armed_q     <= 1'b0;
      low_cnt_q        <= 5'h0;
      sec_cnt_q        <= 14'h0;
      act_cnt_q        <= 11'h0;
      wake_idx_q       <= 2'h0;
      wake_check_q     <= 1'b0;
      check_busy_q     <= 1'b0;
      sleep_temp_kelvin_out <= 10'h0;
    end else begin
      if (ship_cmd) ship_armed_q <= 1'b1;
      // Low-time counter; while ship is armed a high line does not clear it
      if (host_one_wire_line_in && !ship_armed_q) low_cnt_q <= 5'h0;
      else if (sec_tick && !line_low_done) low_cnt_q <= low_cnt_q + 5'h1;
      // Quiet seconds, saturating at the no-activity limit
      if (!quiet) act_cnt_q <= 11'h0;
      else if (sec_tick && act_cnt_q < NOACT_SEC)
        act_cnt_q <= act_cnt_q + 11'h1;
      if (!supply_above_por_in) begin
        if (backup_supply_pin_in) mode_q <= `CCP_MODE_HIBER;
        // No backup: the dip restarts the part, so ship is left
        else if (mode_q == `CCP_MODE_SHIP) mode_q <= `CCP_MODE_ACTIVE;
      end else begin
        case (mode_q)
          `CCP_MODE_ACTIVE: begin
            // Armed ship outranks sleep; sleep also needs the line low now
            if (line_low_done && ship_armed_q) begin
              mode_q       <= `CCP_MODE_SHIP;
              ship_armed_q <= 1'b0;
            end else if (line_low_done && quiet &&
                         !host_one_wire_line_in &&
                         act_cnt_q >= CHECK_SEC) begin
              mode_q     <= `CCP_MODE_SLEEP;
              sleep_temp_kelvin_out <= temp_kelvin_in;
              sec_cnt_q  <= 14'h0;
              wake_idx_q <= 2'h0;
            end
          end
          `CCP_MODE_SLEEP: begin
            if (host_one_wire_line_in) begin
              mode_q    <= `CCP_MODE_ACTIVE;
              low_cnt_q <= 5'h0;
            end else if (sec_tick) begin
              if (sec_cnt_q == WAKE_SEC - 1) begin
                mode_q       <= `CCP_MODE_WAKE;
                sec_cnt_q    <= 14'h0;
                wake_check_q <= (wake_idx_q == 2'h0);
                check_busy_q <= 1'b0;
                wake_idx_q   <= (wake_idx_q == `CCP_CHECK_EVERY - 2'h1) ?
                                2'h0 : wake_idx_q + 2'h1;
                act_cnt_q    <= 11'h0;
              end else begin
                sec_cnt_q <= sec_cnt_q + 14'h1;
              end
            end
          end
          `CCP_MODE_WAKE: begin
            // Any activity during the check keeps the part awake
            if (!quiet) check_busy_q <= 1'b1;
            if (host_one_wire_line_in) begin
              mode_q <= `CCP_MODE_ACTIVE;
            end else if (sec_tick) begin
              sec_cnt_q <= sec_cnt_q + 14'h1;
              if (!wake_check_q && sec_cnt_q == LOW_CYC - 1) begin
                mode_q    <= `CCP_MODE_SLEEP;
                sec_cnt_q <= 14'h0;
                // Fresh wake temperature sets the self-discharge rate
                sleep_temp_kelvin_out <= temp_kelvin_in;
              end else if (wake_check_q && sec_cnt_q == CHECK_SEC - 1) begin
                sec_cnt_q <= 14'h0;
                if (quiet && !check_busy_q) begin
                  mode_q                <= `CCP_MODE_SLEEP;
                  sleep_temp_kelvin_out <= temp_kelvin_in;
                end else begin
                  mode_q <= `CCP_MODE_ACTIVE;
                end
              end
            end
          end
          `CCP_MODE_SHIP: begin
            if (host_one_wire_line_in) mode_q <= `CCP_MODE_ACTIVE;
          end
          default: mode_q <= `CCP_MODE_ACTIVE;
        endcase
      end
    end
  end

  always @* power_mode_out = mode_q;
  assign gauge_enable_out      = gauging;
  assign self_discharge_en_out = (mode_q == `CCP_MODE_SLEEP);
  assign retain_state_out      = (mode_q == `CCP_MODE_HIBER);
endmodule // ccp_capacity_comp

// [verification/ccp_capacity_comp_sva.sv]
`timescale 1ns/1ns
`include "ccp_defines.vh"
module ccp_capacity_comp_sva #(
  parameter LOW_CYC     = `CCP_LOW_SEC,
  parameter CYC_PER_SEC = `CCP_CLK_HZ
) (
  // Clock and reset
  input wire        ref_clk_in,
  input wire        arst_n_in,
  // Stimulus
  input wire        reg_wr_in,
  input wire [6:0]  reg_addr_in,
  input wire [7:0]  reg_wdata_in,
  input wire        ship_bit_in,
  input wire        host_one_wire_line_in,
  input wire        activity_in,
  input wire        supply_above_por_in,
  input wire        backup_supply_pin_in,
  // Results
  input wire [12:0] term_voltage_mv_out,
  input wire [15:0] rate_compensated_charge_out,
  input wire [2:0]  power_mode_out,
  input wire        gauge_enable_out,
  input wire        self_discharge_en_out,
  input wire        retain_state_out
);
  // One second of slack: the design counts whole seconds from a free tick
  localparam int LOW_MIN = (LOW_CYC - 1) * CYC_PER_SEC;
  reg  [31:0] low_cnt_q;
  reg         armed_q;
  wire        asleep = power_mode_out == `CCP_MODE_SLEEP;
  wire        in_ship = power_mode_out == `CCP_MODE_SHIP;
  function automatic [12:0] tv_of(input [1:0] s);
    tv_of = s[1] ? (s[0] ? `CCP_TV_11 : `CCP_TV_10)
                 : (s[0] ? `CCP_TV_01 : `CCP_TV_00);
  endfunction
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_q <= 32'h0;
      armed_q   <= 1'b0;
    end else begin
      low_cnt_q <= host_one_wire_line_in ? 32'h0 : low_cnt_q + 32'h1;
      if (in_ship)
        armed_q <= 1'b0;
      else if (reg_wr_in && reg_addr_in == `CCP_ADDR_CTRL &&
               reg_wdata_in == `CCP_SHIP_CMD && ship_bit_in)
        armed_q <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_term_volt_map: assert property (
    reg_wr_in && reg_addr_in == `CCP_ADDR_PACK_CONFIG_BYTE && power_mode_out == 3'h0
    |-> ##2 term_voltage_mv_out == tv_of($past(reg_wdata_in[6:5], 2)))
    else $error("termination voltage does not follow select bits");
  a_sleep_after_low: assert property (
    $rose(asleep) |-> low_cnt_q >= LOW_MIN)
    else $error("sleep entered without a long enough low line");
  a_busy_no_sleep: assert property (
    power_mode_out == `CCP_MODE_ACTIVE &&
    (activity_in || host_one_wire_line_in) |=> !asleep)
    else $error("sleep entered with activity or line high");
  a_line_wakes: assert property (
    asleep && host_one_wire_line_in && supply_above_por_in
    |-> ##[1:3] power_mode_out == `CCP_MODE_ACTIVE)
    else $error("line high did not end sleep");
  a_ship_armed: assert property (
    $rose(in_ship) |-> armed_q && low_cnt_q >= LOW_MIN)
    else $error("ship entered without command or low period");
  a_ship_exit: assert property (
    in_ship && host_one_wire_line_in && supply_above_por_in
    |-> ##[1:3] power_mode_out == `CCP_MODE_ACTIVE)
    else $error("line high did not end ship");
  a_hibernate_entry: assert property (
    !supply_above_por_in && backup_supply_pin_in
    |-> ##[1:3] power_mode_out == `CCP_MODE_HIBER && retain_state_out)
    else $error("low supply with backup did not hibernate");
  a_sleep_no_gauge: assert property (
    asleep |-> !gauge_enable_out && self_discharge_en_out)
    else $error("gauging or self discharge wrong in sleep");
  a_sleep_frozen: assert property (
    asleep && $past(asleep) |-> $stable(rate_compensated_charge_out))
    else $error("charge result moved while asleep");
endmodule // ccp_capacity_comp_sva

// [verification/ccp_host_model.sv]
`timescale 1ns/1ns
module ccp_host_model (
  // Clock
  input  wire       ref_clk_in,
  // Line and register port
  output reg        host_line_out,
  output reg        reg_wr_out,
  output reg  [6:0] reg_addr_out,
  output reg  [7:0] reg_wdata_out,
  output reg        ship_bit_out
);
  initial begin
    host_line_out = 1'b1;
    reg_wr_out    = 1'b0;
    reg_addr_out  = 7'h00;
    reg_wdata_out = 8'h00;
    ship_bit_out  = 1'b0;
  end
  task automatic wr(input [6:0] a, input [7:0] d);
    @(negedge ref_clk_in);
    reg_wr_out    <= 1'b1;
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    @(negedge ref_clk_in);
    reg_wr_out    <= 1'b0;
    // Released data must not look like the last byte
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input [6:0] a);
    @(negedge ref_clk_in);
    reg_addr_out <= a;
    @(negedge ref_clk_in);
  endtask
  task automatic set_line(input v);
    @(negedge ref_clk_in);
    host_line_out <= v;
  endtask
  task automatic arm_ship;
    @(negedge ref_clk_in);
    ship_bit_out <= 1'b1;
    wr(7'h00, 8'hA9);
  endtask
endmodule // ccp_host_model

// [verification/ccp_capacity_comp_tb.sv]
`timescale 1ns/1ns
`include "ccp_defines.vh"
module ccp_capacity_comp_tb;
  reg          ref_clk_in;
  reg          arst_n_in;
  reg  [15:0]  nom, cap, avg, adj;
  reg  [15:0]  rnd = 16'hCE82;
  reg  [9:0]   tk;
  reg          end_evt, full_evt, act, cvp;
  reg          sup, bak;
  reg  [3:0]   mf;
  wire         line, wr, shipb, gen, sden, ret, dq;
  wire [6:0]   addr;
  wire [7:0]   wdata, rdata;
  wire [12:0]  tv;
  wire [15:0]  rchg, tchg;
  wire [9:0]   stk;
  wire [2:0]   mode;
  int          n_mismatch = 0, total_checks = 0;
  int          sel_q[$];
  logic [15:0] exp_q[$];
  event        look;
  string       nm[8] = '{"rdata", "term_mv", "rate_chg", "temp_chg",
                         "mode", "cold", "retain", "slp_temp"};
  always #10 ref_clk_in = ~ref_clk_in;
  ccp_host_model ccp_host_model_inst (.ref_clk_in(ref_clk_in),
    .host_line_out(line), .reg_wr_out(wr), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .ship_bit_out(shipb));
  ccp_capacity_comp #(.LOW_CYC(2), .WAKE_SEC(5), .CHECK_SEC(3),
    .NOACT_SEC(4), .CYC_PER_SEC(4)) ccp_capacity_comp_inst (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .ship_bit_in(shipb), .nominal_available_charge_in(nom),
    .learned_full_capacity_in(cap), .initial_full_capacity_in(cap),
    .average_current_in(avg), .temp_kelvin_in(tk),
    .first_end_voltage_event_in(end_evt), .full_charge_event_in(full_evt),
    .host_one_wire_line_in(line), .magnitude_filter_in(mf),
    .activity_in(act), .current_converter_pulse_in(cvp),
    .supply_above_por_in(sup), .backup_supply_pin_in(bak),
    .term_voltage_mv_out(tv), .rate_compensated_charge_out(rchg),
    .temp_compensated_charge_out(tchg), .sleep_temp_kelvin_out(stk),
    .learn_disqualify_out(dq), .power_mode_out(mode),
    .gauge_enable_out(gen), .self_discharge_en_out(sden),
    .retain_state_out(ret));
  function automatic [15:0] step(input [15:0] v);
    step = v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
  endfunction
  function automatic [15:0] disc_comp(input [5:0] g, input [1:0] c);
    logic [15:0] t;
    t = (c == 2'h0) ? 16'h0 : (cap >> c);
    disc_comp = (avg > t) ? 16'((22'(g) * 22'(avg - t)) >> 8) : 16'h0;
  endfunction
  function automatic [15:0] rate_exp(input [15:0] d);
    rate_exp = (d > adj) ? nom - (d - adj) : nom;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic put(input int s, input [15:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    -> look;
  endtask
  task automatic chk(input [15:0] r, input [15:0] t);
    tick(3);
    put(2, r);
    put(3, t);
  endtask
  task automatic pulse_evt(input bit is_end);
    tick(1);
    if (is_end) end_evt <= 1'b1;
    else full_evt <= 1'b1;
    tick(1);
    end_evt  <= 1'b0;
    full_evt <= 1'b0;
  endtask
  task automatic wait_mode(input [2:0] m, input int n);
    for (int k = 0; k < n && mode !== m; k++) tick(1);
    put(4, {13'h0, m});
  endtask
  task automatic compare(input int s, input [15:0] e, input [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm[s], e, g);
      n_mismatch++;
    end
  endtask
  always @(look) begin : mon
    int s;
    logic [15:0] e, g;
    while (exp_q.size() > 0) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      case (s)
        0: g = {8'h00, rdata};
        1: g = {3'h0, tv};
        2: g = rchg;
        3: g = tchg;
        4: g = {13'h0, mode};
        5: g = {15'h0, dq};
        6: g = {15'h0, ret};
        default: g = {6'h0, stk};
      endcase
      compare(s, e, g);
    end
  end
  task automatic give_verdict;
    #1;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin : watchdog
    #400000;
    n_mismatch++;
    give_verdict;
  end
  initial begin : main
    logic [12:0] tvt[4];
    logic [15:0] d;
    logic [7:0]  b;
    ref_clk_in = 1'b0;
    arst_n_in  = 1'b0;
    {nom, cap, avg, adj} = 64'h0;
    {end_evt, full_evt, act, cvp, bak} = 5'h0;
    tk  = 10'h190;
    sup = 1'b1;
    mf  = 4'h3;
    tvt = '{13'h0F80, 13'h0FB0, 13'h0FE0, 13'h1010};
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in) arst_n_in <= 1'b1;
    pulse_evt(1'b0);
    for (int i = 124; i < 128; i++) begin
      ccp_host_model_inst.rd(7'(i));
      put(0, 16'h0);
    end
    for (int i = 125; i < 128; i++) begin
      rnd = step(rnd);
      ccp_host_model_inst.wr(7'(i), rnd[7:0]);
      ccp_host_model_inst.rd(7'(i));
      put(0, {8'h0, rnd[7:0]});
    end
    // Unmapped places take no write and read as zero
    ccp_host_model_inst.wr(7'h10, 8'h5A);
    ccp_host_model_inst.rd(7'h10);
    put(0, 16'h0);
    ccp_host_model_inst.wr(7'h7F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ccp_host_model_inst.wr(7'h7C, {1'b0, 2'(i), 5'h00});
      tick(3);
      put(1, {3'h0, tvt[i]});
    end
    for (int i = 0; i < 4; i++) begin
      rnd = step(rnd);
      cap = rnd;
      rnd = step(rnd);
      avg = rnd;
      rnd = step(rnd);
      nom = rnd | 16'h8000;
      b = {rnd[7:2], 2'(i)};
      ccp_host_model_inst.wr(7'h7E, b);
      d = disc_comp(b[7:2], b[1:0]);
      chk(nom - d, nom - d);
    end
    pulse_evt(1'b1);
    adj = d;
    avg = 16'hF000;
    d = disc_comp(b[7:2], b[1:0]);
    chk(rate_exp(d), rate_exp(d));
    avg = 16'h0000;
    chk(nom, nom);
    ccp_host_model_inst.wr(7'h7C, 8'h02);
    avg = 16'hF000;
    d = disc_comp(6'h10, 2'h2);
    chk(rate_exp(d), rate_exp(d));
    ccp_host_model_inst.rd(7'h7E);
    put(0, {8'h0, b});
    avg = 16'h0000;
    cap = 16'h0064;
    nom = 16'h4000;
    ccp_host_model_inst.wr(7'h7C, 8'h00);
    ccp_host_model_inst.wr(7'h7F, 8'h2A);
    tk = 10'h118;
    chk(nom, nom - 16'd150);
    put(5, 16'h1);
    ccp_host_model_inst.wr(7'h7C, 8'h01);
    tk = 10'h11B;
    chk(nom, nom - 16'd350);
    pulse_evt(1'b1);
    tk = 10'h11A;
    chk(nom, nom - 16'd175);
    pulse_evt(1'b0);
    chk(nom, nom - 16'd525);
    tk = 10'h190;
    chk(nom, nom);
    put(5, 16'h0);
    act = 1'b1;
    ccp_host_model_inst.set_line(1'b0);
    tick(60);
    put(4, 16'h0);
    act = 1'b0;
    wait_mode(`CCP_MODE_SLEEP, 400);
    wait_mode(`CCP_MODE_WAKE, 200);
    wait_mode(`CCP_MODE_SLEEP, 400);
    wait_mode(`CCP_MODE_WAKE, 200);
    wait_mode(`CCP_MODE_SLEEP, 10);
    ccp_host_model_inst.set_line(1'b1);
    wait_mode(`CCP_MODE_ACTIVE, 4);
    ccp_host_model_inst.arm_ship;
    ccp_host_model_inst.set_line(1'b0);
    wait_mode(`CCP_MODE_SHIP, 400);
    ccp_host_model_inst.set_line(1'b1);
    wait_mode(`CCP_MODE_ACTIVE, 4);
    ccp_host_model_inst.set_line(1'b0);
    wait_mode(`CCP_MODE_SLEEP, 400);
    ccp_host_model_inst.set_line(1'b1);
    wait_mode(`CCP_MODE_ACTIVE, 4);
    sup = 1'b0;
    bak = 1'b1;
    wait_mode(`CCP_MODE_HIBER, 4);
    put(6, 16'h1);
    sup = 1'b1;
    wait_mode(`CCP_MODE_ACTIVE, 20);
    mf  = 4'h0;
    cvp = 1'b1;
    tk  = 10'h150;
    ccp_host_model_inst.set_line(1'b0);
    tick(60);
    put(4, 16'h0);
    cvp = 1'b0;
    wait_mode(`CCP_MODE_SLEEP, 400);
    put(7, 16'h0150);
    tick(2);
    give_verdict;
  end
endmodule // ccp_capacity_comp_tb
bind ccp_capacity_comp ccp_capacity_comp_sva #(.LOW_CYC(LOW_CYC),
  .CYC_PER_SEC(CYC_PER_SEC)) ccp_capacity_comp_sva_inst (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .ship_bit_in(ship_bit_in), .host_one_wire_line_in(host_one_wire_line_in),
  .activity_in(activity_in), .supply_above_por_in(supply_above_por_in),
  .backup_supply_pin_in(backup_supply_pin_in),
  .term_voltage_mv_out(term_voltage_mv_out),
  .rate_compensated_charge_out(rate_compensated_charge_out),
  .power_mode_out(power_mode_out), .gauge_enable_out(gauge_enable_out),
  .self_discharge_en_out(self_discharge_en_out),
  .retain_state_out(retain_state_out));
